// ### logic/ppcr_regs.sv
`timescale 1ns/1ns
module ppcr_regs #(
  parameter int unsigned RETRY_CYC_2S0 =
    ppcr_pkg::RETRY_2S0_MS * ppcr_pkg::CLK_FREQ_KHZ,
  parameter int unsigned RETRY_CYC_1S0 =
    ppcr_pkg::RETRY_1S0_MS * ppcr_pkg::CLK_FREQ_KHZ,
  parameter int unsigned RETRY_CYC_0S5 =
    ppcr_pkg::RETRY_0S5_MS * ppcr_pkg::CLK_FREQ_KHZ,
  parameter int unsigned RETRY_CYC_16M =
    ppcr_pkg::RETRY_16_MS * ppcr_pkg::CLK_FREQ_KHZ
) (
  input  wire logic                sys_clk,
  input  wire logic                sys_rst,
  input  wire ppcr_pkg::ppcr_req_t regReq,
  output logic [7:0]               regRdData,
  input  wire logic                extBiasPresent,
  input  wire logic                currentAboveTarget,
  input  wire logic                faultEvent,
  input  wire logic                shieldStatus,
  input  wire logic                modeChangeStatus,
  output ppcr_pkg::ppcr_cfg_t      cfg,
  output logic                     internalBiasOn,
  output logic                     currentLimitMode,
  output logic                     vendorAlert,
  output logic                     retryActive,
  output logic                     retryDone,
  output logic                     biasLossReset
);
  import ppcr_pkg::*;

  logic [NUM_REGS-1:0][7:0] regs_q;
  logic [NUM_REGS-1:0]      hit;
  logic [NUM_REGS-1:0][7:0] rdTerm;
  logic [7:0]               rdMux;
  logic [7:0]               rdData_q;
  logic [2:0]               biasSync_q;
  logic                     biasOk_q;
  logic [2:0]               overSync_q;
  logic                     over_q;
  logic                     clMode_q;
  logic                     alert_q;
  logic                     biasReset;
  logic                     clModeRaw;
  logic                     alertRaw;

  // ******************************
  // pin synchronisers
  // ******************************
  // a new level is taken only once stages two and three agree
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      biasSync_q <= '0;
      overSync_q <= '0;
    end else begin
      biasSync_q <= {biasSync_q[1:0], extBiasPresent};
      overSync_q <= {overSync_q[1:0], currentAboveTarget};
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      biasOk_q <= 1'b0;
      over_q   <= 1'b0;
    end else begin
      if (biasSync_q[2] == biasSync_q[1]) begin
        biasOk_q <= biasSync_q[2];
      end
      if (overSync_q[2] == overSync_q[1]) begin
        over_q <= overSync_q[2];
      end
    end
  end

  // ******************************
  // register file
  // ******************************
  // missing external bias resets
  // the internal regulator is off, so the bank cannot hold its contents
  assign biasReset = regs_q[IDX_GENERAL][POS_BIAS_SEL] && !biasOk_q;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
      assign hit[gi] = (regReq.addr == REG_ADDR[gi]);
      assign rdTerm[gi] = hit[gi] ? (regs_q[gi] & REG_MASK[gi]) : 8'h00;

      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          regs_q[gi] <= REG_RESET[gi];
        end else if (biasReset) begin
          regs_q[gi] <= REG_RESET[gi];
        end else if (regReq.wrEn && hit[gi]) begin
          regs_q[gi] <= regReq.wrData & REG_MASK[gi];
        end
      end
    end
  endgenerate

  // unmapped addresses read zero and ignore writes
  always_comb begin
    rdMux = 8'h00;
    for (int i = 0; i < NUM_REGS; i++) begin
      rdMux = rdMux | rdTerm[i];
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdData_q <= 8'h00;
    end else if (regReq.rdEn) begin
      rdData_q <= rdMux;
    end
  end

  assign regRdData = rdData_q;

  // ******************************
  // field decode
  // ******************************
  // retry wait field
  assign cfg.faultRetryWait = ppcr_retry_t'(regs_q[IDX_RETRY][1:0]);
  assign cfg.targetFineStep = regs_q[IDX_GENERAL][POS_FINE_STEP];
  assign cfg.biasSourceSelect = regs_q[IDX_GENERAL][POS_BIAS_SEL];
  assign cfg.currentLimitRegulationOn = regs_q[IDX_GENERAL][POS_CL_ON];
  assign cfg.chargeDetectMode = ppcr_charge_t'(regs_q[IDX_GENERAL][1:0]);
  assign cfg.inputLowVoltageLevel = regs_q[IDX_INPUT_UV][3:0];
  assign cfg.cablePowerOvercurrentLevel = regs_q[IDX_VCONN][7:4];
  assign cfg.cablePowerLowVoltageLevel = regs_q[IDX_VCONN][2:0];
  assign cfg.busHighVoltageMargin = regs_q[IDX_VBUS][6:4];
  assign cfg.busLowVoltageMargin = regs_q[IDX_VBUS][2:0];
  assign cfg.busCurrentLimitTarget = regs_q[IDX_CUR_LIMIT];
  assign cfg.shieldAlertEnable =
      regs_q[IDX_VENDOR_MASK][POS_SHIELD_MASK];
  assign cfg.regulationModeChangeAlertEnable =
      regs_q[IDX_VENDOR_MASK][POS_MODE_MASK];

  assign internalBiasOn = !cfg.biasSourceSelect;

  // ******************************
  // current limit and alert
  // ******************************
  // enter limit when above
  assign clModeRaw = cfg.currentLimitRegulationOn && over_q;
  // masked vendor alert
  // mode changes only mean something while regulation is on
  assign alertRaw =
      (cfg.shieldAlertEnable && shieldStatus) ||
      (cfg.regulationModeChangeAlertEnable && modeChangeStatus &&
       cfg.currentLimitRegulationOn);

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clMode_q <= 1'b0;
      alert_q  <= 1'b0;
    end else begin
      clMode_q <= clModeRaw;
      alert_q  <= alertRaw;
    end
  end

  assign currentLimitMode = clMode_q;
  assign vendorAlert      = alert_q;
  assign biasLossReset    = biasReset;

  // ******************************
  // retry timer
  // ******************************
  // wait after a fault
  ppcr_retry_timer #(
    .CYC_2S0 (RETRY_CYC_2S0),
    .CYC_1S0 (RETRY_CYC_1S0),
    .CYC_0S5 (RETRY_CYC_0S5),
    .CYC_16M (RETRY_CYC_16M)
  ) u_retry (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .start   (faultEvent),
    .waitSel (cfg.faultRetryWait),
    .busy    (retryActive),
    .done    (retryDone)
  );

endmodule : ppcr_regs

// ### logic/ppcr_pkg.sv
package ppcr_pkg;

  // ******************************
  // register map
  // ******************************
  localparam int NUM_REGS = 7;
  localparam logic [7:0] ADDR_CUR_LIMIT   = 8'h82;
  localparam logic [7:0] ADDR_RETRY       = 8'h85;
  localparam logic [7:0] ADDR_GENERAL     = 8'h86;
  localparam logic [7:0] ADDR_INPUT_UV    = 8'h87;
  localparam logic [7:0] ADDR_VCONN       = 8'h88;
  localparam logic [7:0] ADDR_VBUS        = 8'h89;
  localparam logic [7:0] ADDR_VENDOR_MASK = 8'h8a;

  localparam logic [NUM_REGS-1:0][7:0] REG_ADDR = {
    ADDR_VENDOR_MASK, ADDR_VBUS, ADDR_VCONN, ADDR_INPUT_UV,
    ADDR_GENERAL, ADDR_RETRY, ADDR_CUR_LIMIT};
  // writable bits; all others are reserved and read zero
  localparam logic [NUM_REGS-1:0][7:0] REG_MASK = {
    8'h81, 8'h77, 8'hf7, 8'h0f, 8'h57, 8'h03, 8'hff};
  localparam logic [NUM_REGS-1:0][7:0] REG_RESET = {
    8'h81, 8'h33, 8'h63, 8'h00, 8'h04, 8'h03, 8'h80};

  localparam int IDX_CUR_LIMIT   = 0;
  localparam int IDX_RETRY       = 1;
  localparam int IDX_GENERAL     = 2;
  localparam int IDX_INPUT_UV    = 3;
  localparam int IDX_VCONN       = 4;
  localparam int IDX_VBUS        = 5;
  localparam int IDX_VENDOR_MASK = 6;

  // ******************************
  // field positions
  // ******************************
  localparam int POS_FINE_STEP   = 6;
  localparam int POS_BIAS_SEL    = 4;
  localparam int POS_CL_ON       = 2;
  localparam int POS_SHIELD_MASK = 7;
  localparam int POS_MODE_MASK   = 0;

  // ******************************
  // timing
  // ******************************
  localparam int unsigned CLK_FREQ_KHZ  = 125000;
  localparam int unsigned RETRY_2S0_MS  = 2000;
  localparam int unsigned RETRY_1S0_MS  = 1000;
  localparam int unsigned RETRY_0S5_MS  = 500;
  localparam int unsigned RETRY_16_MS   = 16;
  localparam int          RETRY_CNT_W   = 28;

  // ******************************
  // types
  // ******************************
  typedef enum logic [1:0] {
    RETRY_WAIT_2S0 = 2'h0,
    RETRY_WAIT_1S0 = 2'h1,
    RETRY_WAIT_0S5 = 2'h2,
    RETRY_WAIT_16M = 2'h3
  } ppcr_retry_t;

  typedef enum logic [1:0] {
    CHG_PASS_THROUGH = 2'h0,
    CHG_AUTO_CDP     = 2'h1,
    CHG_DEDICATED_24 = 2'h2,
    CHG_DEDICATED_10 = 2'h3
  } ppcr_charge_t;

  typedef struct packed {
    ppcr_retry_t  faultRetryWait;
    logic         targetFineStep;
    logic         biasSourceSelect;
    logic         currentLimitRegulationOn;
    ppcr_charge_t chargeDetectMode;
    logic [3:0]   inputLowVoltageLevel;
    logic [3:0]   cablePowerOvercurrentLevel;
    logic [2:0]   cablePowerLowVoltageLevel;
    logic [2:0]   busHighVoltageMargin;
    logic [2:0]   busLowVoltageMargin;
    logic [7:0]   busCurrentLimitTarget;
    logic         shieldAlertEnable;
    logic         regulationModeChangeAlertEnable;
  } ppcr_cfg_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wrData;
    logic       wrEn;
    logic       rdEn;
  } ppcr_req_t;

endpackage : ppcr_pkg

// ### logic/ppcr_retry_timer.sv
`timescale 1ns/1ns
module ppcr_retry_timer #(
  parameter int unsigned CYC_2S0 = 250000000,
  parameter int unsigned CYC_1S0 = 125000000,
  parameter int unsigned CYC_0S5 = 62500000,
  parameter int unsigned CYC_16M = 2000000
) (
  input  wire logic                  sys_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  start,
  input  wire ppcr_pkg::ppcr_retry_t waitSel,
  output logic                       busy,
  output logic                       done
);
  import ppcr_pkg::*;

  logic [RETRY_CNT_W-1:0] cnt_q;
  logic [RETRY_CNT_W-1:0] cnt_d;
  logic                   busy_q;
  logic                   busy_d;
  logic                   done_q;
  logic [RETRY_CNT_W-1:0] loadVal;
  logic                   lastCycle;

  // ******************************
  // wait length
  // ******************************
  // retry wait select
  assign loadVal =
      (waitSel == RETRY_WAIT_2S0) ? RETRY_CNT_W'(CYC_2S0 - 1) :
      (waitSel == RETRY_WAIT_1S0) ? RETRY_CNT_W'(CYC_1S0 - 1) :
      (waitSel == RETRY_WAIT_0S5) ? RETRY_CNT_W'(CYC_0S5 - 1) :
                                    RETRY_CNT_W'(CYC_16M - 1);

  assign lastCycle = busy_q && (cnt_q == '0);
  // a fault during the wait does not restart it
  assign busy_d = (start && !busy_q) || (busy_q && !lastCycle);
  assign cnt_d  = (start && !busy_q) ? loadVal :
                  busy_q ? cnt_q - RETRY_CNT_W'(1) : cnt_q;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
      done_q <= lastCycle;
    end
  end

  assign busy = busy_q;
  assign done = done_q;

endmodule : ppcr_retry_timer

// ### verification/ppcr_host_model.sv
`timescale 1ns/1ns
// ******************************
// serial host stand-in
// ******************************
module ppcr_host_model (
  input  wire logic           sys_clk,
  output ppcr_pkg::ppcr_req_t regReq
);
  import ppcr_pkg::*;
  initial regReq = '0;
  // caller keeps bias and codes legal
  task automatic access(input logic [7:0] a, input logic [7:0] d,
                        input logic wr);
    @(posedge sys_clk);
    regReq <= '{addr: a, wrData: d, wrEn: wr, rdEn: !wr};
    @(posedge sys_clk);
    // released lines flip so a stale value never reads as valid
    regReq <= '{addr: ~a, wrData: ~d, wrEn: 1'b0, rdEn: 1'b0};
  endtask : access
endmodule : ppcr_host_model

// ### verification/ppcr_assertions.sv
`timescale 1ns/1ns
module ppcr_assertions #(
  parameter int unsigned RETRY_CYC_2S0 = 40,
  parameter int unsigned RETRY_CYC_1S0 = 20,
  parameter int unsigned RETRY_CYC_0S5 = 10,
  parameter int unsigned RETRY_CYC_16M = 4
) (
  input wire logic                sys_clk,
  input wire logic                sys_rst,
  input wire ppcr_pkg::ppcr_req_t regReq,
  input wire logic [7:0]          regRdData,
  input wire logic                extBiasPresent,
  input wire logic                currentAboveTarget,
  input wire logic                faultEvent,
  input wire logic                shieldStatus,
  input wire logic                modeChangeStatus,
  input wire ppcr_pkg::ppcr_cfg_t cfg,
  input wire logic                currentLimitMode,
  input wire logic                vendorAlert,
  input wire logic                retryActive,
  input wire logic                retryDone,
  input wire logic                biasLossReset
);
  import ppcr_pkg::*;
  // ******************************
  // helpers
  // ******************************
  logic [31:0] runCnt_q;
  logic [31:0] runCnt_d;
  logic [31:0] lenW;
  logic        alertW;
  assign runCnt_d = retryActive ? runCnt_q + 32'h1 : 32'h0;
  assign lenW = (cfg.faultRetryWait == RETRY_WAIT_2S0) ? RETRY_CYC_2S0 :
                (cfg.faultRetryWait == RETRY_WAIT_1S0) ? RETRY_CYC_1S0 :
                (cfg.faultRetryWait == RETRY_WAIT_0S5) ? RETRY_CYC_0S5 :
                RETRY_CYC_16M;
  assign alertW = (cfg.shieldAlertEnable && shieldStatus) ||
    (cfg.regulationModeChangeAlertEnable && modeChangeStatus &&
     cfg.currentLimitRegulationOn);
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) runCnt_q <= 32'h0;
    else runCnt_q <= runCnt_d;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence highLoad;
    (currentAboveTarget && cfg.currentLimitRegulationOn) [*7];
  endsequence
  sequence biasMissing;
    (cfg.biasSourceSelect && !extBiasPresent) [*5];
  endsequence
  // ******************************
  // properties
  // ******************************
  // limit entry
  limit_enter_a: assert property (highLoad |=> currentLimitMode)
    else $error("limit mode not entered");
  limit_block_a: assert property (
    !cfg.currentLimitRegulationOn |=> !currentLimitMode)
    else $error("limit mode while regulation off");
  alert_mask_a: assert property (
    1'b1 |=> vendorAlert == $past(alertW))
    else $error("vendor alert wrong");
  bias_loss_a: assert property (biasMissing |-> biasLossReset)
    else $error("missing bias not caught");
  loss_default_a: assert property (
    biasLossReset |=> !cfg.biasSourceSelect &&
      cfg.currentLimitRegulationOn && cfg.busLowVoltageMargin == 3'h3)
    else $error("defaults not restored");
  unmapped_read_a: assert property (
    regReq.rdEn && regReq.addr == 8'h80 |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  retry_start_a: assert property (
    faultEvent && !retryActive |=> retryActive)
    else $error("retry wait not started");
  retry_len_a: assert property (
    $fell(retryActive) |-> runCnt_q == lenW)
    else $error("retry wait length wrong");
  retry_done_a: assert property (
    $fell(retryActive) |-> ##[0:1] retryDone)
    else $error("retry done missing");
endmodule : ppcr_assertions

bind ppcr_regs ppcr_assertions #(
  .RETRY_CYC_2S0(RETRY_CYC_2S0), .RETRY_CYC_1S0(RETRY_CYC_1S0),
  .RETRY_CYC_0S5(RETRY_CYC_0S5), .RETRY_CYC_16M(RETRY_CYC_16M)
) ppcr_assertions_i (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .regReq(regReq),
  .regRdData(regRdData), .extBiasPresent(extBiasPresent),
  .currentAboveTarget(currentAboveTarget), .faultEvent(faultEvent),
  .shieldStatus(shieldStatus), .modeChangeStatus(modeChangeStatus),
  .cfg(cfg), .currentLimitMode(currentLimitMode),
  .vendorAlert(vendorAlert), .retryActive(retryActive),
  .retryDone(retryDone), .biasLossReset(biasLossReset)
);

// ### verification/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import ppcr_pkg::*;
  logic       sys_clk, sys_rst, extBiasPresent, currentAboveTarget;
  logic       faultEvent, shieldStatus, modeChangeStatus;
  logic       internalBiasOn, currentLimitMode, vendorAlert;
  logic       retryActive, retryDone, biasLossReset;
  logic [7:0] regRdData;
  ppcr_req_t  regReq;
  ppcr_cfg_t  cfg;
  int         mismatches, checked, cycles;
  logic [7:0] expQ[$];
  localparam int N[4] = '{40, 20, 10, 4};
  ppcr_regs #(.RETRY_CYC_2S0(40), .RETRY_CYC_1S0(20), .RETRY_CYC_0S5(10),
    .RETRY_CYC_16M(4)) ppcr_regs_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .regReq(regReq), .regRdData(regRdData), .extBiasPresent(extBiasPresent),
    .currentAboveTarget(currentAboveTarget), .faultEvent(faultEvent),
    .shieldStatus(shieldStatus), .modeChangeStatus(modeChangeStatus),
    .cfg(cfg), .internalBiasOn(internalBiasOn),
    .currentLimitMode(currentLimitMode), .vendorAlert(vendorAlert),
    .retryActive(retryActive), .retryDone(retryDone),
    .biasLossReset(biasLossReset));
  ppcr_host_model ppcr_host_model_i (.sys_clk(sys_clk), .regReq(regReq));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // ******************************
  // helpers
  // ******************************
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    ppcr_host_model_i.access(a, d, 1'b1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back(e);
    ppcr_host_model_i.access(a, 8'h00, 1'b0);
  endtask : rd
  task automatic dflt();
    for (int i = 0; i < NUM_REGS; i++) rd(REG_ADDR[i], REG_RESET[i]);
    rd(8'h80, 8'h00);
  endtask : dflt
  task automatic complete_run();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  // read answers are registered on the strobe edge and checked at the next falling edge
  always @(posedge sys_clk) begin
    if (regReq.rdEn === 1'b1) begin
      @(negedge sys_clk);
      chk("read data", expQ.pop_front(), regRdData);
    end
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      complete_run();
    end
  end
  // ******************************
  // main sequence
  // ******************************
  initial begin
    logic [7:0] d;
    logic       s, c;
    int         n;
    {sys_rst, extBiasPresent, currentAboveTarget} = 3'h4;
    {faultEvent, shieldStatus, modeChangeStatus} = 3'h0;
    {mismatches, checked, cycles} = '0;
    void'($urandom(36328));
    cyc(20);
    sys_rst <= 1'b0;
    dflt();
    $display("test defaults done");
    extBiasPresent <= 1'b1;
    repeat (2) for (int i = 0; i < NUM_REGS; i++) begin
      d = 8'($urandom) & REG_MASK[i];
      if (i == IDX_INPUT_UV) d[3:0] = 4'($urandom % 11);
      if (i == IDX_VCONN) d[7:4] = 4'($urandom % 10);
      wr(REG_ADDR[i], d | ~REG_MASK[i]);
      rd(REG_ADDR[i], d);
    end
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_GENERAL, 8'h44 | 8'(m));
      cyc(1);
      chk("charge mode", 8'(cfg.chargeDetectMode), 8'(m));
      chk("fine step", 8'(cfg.targetFineStep), 8'h01);
    end
    $display("test fields done");
    wr(ADDR_GENERAL, 8'h14);
    cyc(2);
    chk("internal bias", 8'(internalBiasOn), 8'h00);
    wr(ADDR_VBUS, 8'h70);
    extBiasPresent <= 1'b0;
    cyc(8);
    dflt();
    wr(ADDR_GENERAL, 8'h14);
    cyc(4);
    chk("bias select", 8'(cfg.biasSourceSelect), 8'h00);
    $display("test bias done");
    wr(ADDR_GENERAL, 8'h04);
    currentAboveTarget <= 1'b1;
    cyc(8);
    chk("limit on", 8'(currentLimitMode), 8'h01);
    wr(ADDR_GENERAL, 8'h00);
    cyc(2);
    chk("limit off", 8'(currentLimitMode), 8'h00);
    currentAboveTarget <= 1'b0;
    $display("test limit done");
    for (int k = 0; k < 8; k++) begin
      {s, c} = 2'($urandom);
      wr(ADDR_GENERAL, {5'h00, k[2], 2'h0});
      wr(ADDR_VENDOR_MASK, {k[1], 6'h00, k[0]});
      shieldStatus <= s;
      modeChangeStatus <= c;
      cyc(3);
      d = 8'((k[1] & s) | (k[0] & c & k[2]));
      chk("alert", 8'(vendorAlert), d);
    end
    $display("test alert done");
    for (int r = 0; r < 4; r++) begin
      wr(ADDR_RETRY, 8'(r));
      faultEvent <= 1'b1;
      cyc(1);
      faultEvent <= 1'b0;
      n = 0;
      @(negedge sys_clk);
      while (retryActive === 1'b1 && n < 60) begin
        n++;
        @(negedge sys_clk);
      end
      chk("retry length", 8'(n), 8'(N[r]));
    end
    $display("test retry done");
    complete_run();
  end
endmodule : tb_top
